/* isense_pkg.sv */
package isense_pkg;
    // Clock rate in MHz, period 8 ns
    localparam int CLK_MHZ = 125;
    // Fault detect time in microseconds, inside the 30 to 80 us window
    localparam int WATCHDOG_LIMIT_US = 50;
    // Watchdog limit in cycles, the exact product of microseconds and MHz, taken as a longest time
    localparam int WATCHDOG_LIMIT_CYC = WATCHDOG_LIMIT_US * CLK_MHZ;
    // Self-calibration length in cycles after lockout release
    localparam int CAL_CYC = 64;
    // Counter width for reset timer and watchdog
    localparam int CNT_W = 16;
    // Reset values
    localparam logic [CNT_W-1:0] CNT_RESET = 16'h0000;
    localparam logic [1:0] SENSE_RESET = 2'h0;

    // Output modes, one-hot
    typedef enum logic [2:0] {
        MODE_SINGLE = 3'b001,
        MODE_PP2 = 3'b010,
        MODE_PP4 = 3'b100
    } out_mode_t;

    // Calibration sequencer states, one-hot
    typedef enum logic [1:0] {
        ST_CAL = 2'b01,
        ST_RUN = 2'b10
    } run_state_t;

    // Four reset inputs carried together
    typedef struct packed {
        logic d;
        logic c;
        logic b;
        logic a;
    } reset_inputs_t;
endpackage

/* integrator_reset_steer.sv */
`timescale 1ns/1ps
// Contract
// RL1: Single mode always measures on port a
// RL2: Ping-pong alternates cycles between both ports
// RL3: Two-wire: a steers port a, b port b
// RL4: Four-wire: a&!b to b, c&!d to a
// RL5: Mode pin and input d select mode
// RL6: Single dual-variant reset: a xor (b|c)
// RL7: Two-wire reset: a xnor (b|c)
// RL8: Four-wire reset: (a&b) or (c&d)
// RL9: Single-only variant reset: a xor b
// RL10: Timer bypass: reset follows condition exactly
// RL11: Timer enabled when pin not tied high
// RL12: Condition rising edge starts retriggerable pulse
// RL13: Condition false ends reset at once
// RL14: Source holds condition whole reset duration
// RL15: Watchdog holds outputs minimum after timeout
// RL16: Fault detect time fixed within 30-80 us
// RL17: Fault clears when next reset begins
// RL18: Fault state driven onto fault pin
// RL19: Timing signals respect duration and watchdog
// RL20: Calibration after lockout ignores reset inputs
// RL21: Measurement starts right after reset completes
// RL22: Reset duration not below 150 ns; code enforces no floor, a RESET_DURATION_I of 0 or 1 gives an 8 ns pulse
// RL23: Measure enable per selected, enabled, unreset port
module integrator_reset_steer
    import isense_pkg::*;
(
    input wire logic CLOCK_I,
    input wire logic RST_I,
    input wire logic RESET_IN_A_I,
    input wire logic RESET_IN_B_I,
    input wire logic RESET_IN_C_I,
    input wire logic RESET_IN_D_I,
    input wire logic MODE_PIN_I,
    input wire logic DUAL_VARIANT_I,
    input wire logic TIMER_BYPASS_I,
    input wire logic [CNT_W-1:0] RESET_DURATION_I,
    output logic INTEGRATOR_RESET_O,
    output logic SENSE_PORT_A_O,
    output logic SENSE_PORT_B_O,
    output logic FAULT_O,
    output logic CAL_BUSY_O
);
    // Two-stage synchronisers for the four reset inputs and the three configuration pins
    reset_inputs_t rin_meta, rin;
    logic [2:0] cfg_meta, cfg;
    // Calibration sequencer
    run_state_t state;
    logic [CNT_W-1:0] cal_cnt;
    // Reset condition history and timer
    logic cond_q;
    logic [CNT_W-1:0] timer;
    logic timed_active;
    // Watchdog counter and fault flag
    logic [CNT_W-1:0] wd_cnt;
    logic fault;
    // Ping-pong port selection for the current cycle
    logic [1:0] sel;

    // Synchronise pins; first stage feeds only the second
    always_ff @(posedge CLOCK_I) begin
        rin_meta <= {RESET_IN_D_I, RESET_IN_C_I, RESET_IN_B_I, RESET_IN_A_I};
        rin <= rin_meta;
        cfg_meta <= {MODE_PIN_I, DUAL_VARIANT_I, TIMER_BYPASS_I};
        cfg <= cfg_meta;
    end

    wire mode_pin = cfg[2];
    wire dual = cfg[1];
    wire bypass = cfg[0];
    wire running = (state == ST_RUN);

    // Mode decode; single-only variant is always single mode
    out_mode_t mode;
    assign mode = !dual ? MODE_SINGLE :
        (mode_pin ? (rin.d ? MODE_PP2 : MODE_SINGLE) : MODE_PP4); // RL5

    // Reset condition per mode
    wire b_or_c = rin.b | rin.c;
    wire cond_single = dual ? (rin.a ^ b_or_c) : (rin.a ^ rin.b); // RL6 RL9
    wire cond_pp2 = ~(rin.a ^ b_or_c); // RL7
    wire cond_pp4 = (rin.a & rin.b) | (rin.c & rin.d); // RL8
    // Inputs are ignored until calibration ends
    wire cond = running && ((mode == MODE_SINGLE) ? cond_single :
        (mode == MODE_PP2) ? cond_pp2 : cond_pp4); // RL20
    wire cond_rise = cond & ~cond_q; // RL12

    // Effective integrator reset
    wire rst_now = bypass ? cond : (cond & (cond_rise | timed_active)); // RL10 RL11 RL13

    // Port steering in ping-pong modes
    wire [1:0] next_sel = (mode == MODE_PP2) ? {rin.b, rin.a} : // RL3
        (mode == MODE_PP4) ? {rin.a & ~rin.b, rin.c & ~rin.d} : // RL4
        sel;
    wire [1:0] active_sel = (mode == MODE_SINGLE) ? 2'h1 : sel; // RL1 RL2

    // Watchdog expiry and restart
    wire wd_expire = (wd_cnt >= CNT_W'(WATCHDOG_LIMIT_CYC - 1)); // RL16
    wire reset_begin = cond_rise; // RL17

    // Calibration sequencer
    always_ff @(posedge CLOCK_I) begin
        if (RST_I) begin
            state <= ST_CAL;
            cal_cnt <= CNT_RESET;
        end else begin
            case (state)
                ST_CAL: begin
                    // Count out the calibration window
                    cal_cnt <= cal_cnt + 1'b1;
                    if (cal_cnt == CNT_W'(CAL_CYC - 1)) begin
                        state <= ST_RUN; // RL20
                    end
                end
                ST_RUN: begin
                    // Stay in run until the next block reset
                    state <= ST_RUN;
                end
                default: begin
                    // Illegal code falls back to calibration, counting on from the held cal_cnt
                    state <= ST_CAL;
                end
            endcase
        end
    end

    // Retriggerable reset timer; condition drop ends it at once
    always_ff @(posedge CLOCK_I) begin
        if (RST_I) begin
            cond_q <= 1'b0;
            timer <= CNT_RESET;
            timed_active <= 1'b0;
        end else begin
            cond_q <= cond;
            if (!cond) begin
                // Condition gone: the pulse is cut short, accuracy suffers
                timer <= CNT_RESET; // RL13
                timed_active <= 1'b0;
            end else if (cond_rise) begin
                // Fresh rise reloads the duration, so the pulse retriggers
                timer <= RESET_DURATION_I; // RL12
                timed_active <= (RESET_DURATION_I > CNT_W'(1));
            end else if (timer > CNT_W'(1)) begin
                // Count down while the condition stays true
                timer <= timer - 1'b1;
                timed_active <= (timer > CNT_W'(2));
            end else begin
                // Spent: the integrator is released though inputs still ask
                timed_active <= 1'b0;
            end
        end
    end

    // Watchdog: counts between reset starts, fault is sticky till next one
    always_ff @(posedge CLOCK_I) begin
        if (RST_I) begin
            wd_cnt <= CNT_RESET;
            fault <= 1'b0;
        end else if (!running || reset_begin) begin
            // Calibration or a fresh reset start restarts the count
            wd_cnt <= CNT_RESET;
            fault <= 1'b0; // RL17
        end else begin
            // Saturate at the limit so the counter never wraps back to quiet
            if (!wd_expire) begin
                wd_cnt <= wd_cnt + 1'b1;
            end
            if (wd_expire) begin
                fault <= 1'b1; // RL15
            end
        end
    end

    // Hold selection across reset; update from inputs
    always_ff @(posedge CLOCK_I) begin
        if (RST_I) begin
            sel <= SENSE_RESET;
        end else if (next_sel != 2'h0) begin
            // All-zero patterns keep the last port for the coming measurement
            sel <= next_sel;
        end
    end

    // Registered outputs; measure only when enabled and not in reset
    wire measure_ok = running & ~fault & ~rst_now; // RL21 RL23
    always_ff @(posedge CLOCK_I) begin
        if (RST_I) begin
            INTEGRATOR_RESET_O <= 1'b0;
            SENSE_PORT_A_O <= 1'b0;
            SENSE_PORT_B_O <= 1'b0;
            FAULT_O <= 1'b0;
            CAL_BUSY_O <= 1'b1;
        end else begin
            // One register stage after the decode, so outputs never glitch
            INTEGRATOR_RESET_O <= rst_now;
            SENSE_PORT_A_O <= measure_ok & active_sel[0]; // RL23 RL15
            SENSE_PORT_B_O <= measure_ok & active_sel[1]; // RL23 RL15
            FAULT_O <= fault; // RL18
            CAL_BUSY_O <= ~running; // RL20
        end
    end

    // Checks, sampled on the block clock and idle while reset is applied

    // Bypass: running with bypass set, then the condition low one cycle later
    sequence cond_drop_s;
        running && bypass ##1 !cond;
    endsequence

    // Timer: a long pulse starts and the condition is still there next cycle
    sequence timed_start_s;
        running && !bypass && cond_rise && (RESET_DURATION_I > CNT_W'(2)) ##1 cond;
    endsequence

    // Timer: condition still true but the programmed duration is spent
    sequence timer_spent_s;
        running && !bypass && cond && !cond_rise && !timed_active;
    endsequence

    // Bypassed timer: output is the condition one register later
    bypass_follow_a: assert property (@(posedge CLOCK_I) disable iff (RST_I) // RL10
        bypass |=> (INTEGRATOR_RESET_O == $past(cond)))
        else $error("bypass reset does not follow condition");
    // A dropped condition always releases the integrator
    drop_ends_a: assert property (@(posedge CLOCK_I) disable iff (RST_I) // RL13
        !cond |=> !INTEGRATOR_RESET_O)
        else $error("reset not ended on condition drop");
    // Every fresh condition starts a reset
    rise_starts_a: assert property (@(posedge CLOCK_I) disable iff (RST_I) // RL12
        cond_rise |=> INTEGRATOR_RESET_O)
        else $error("condition rise did not start reset");
    // A long timed pulse is not cut after its first cycle
    timed_hold_a: assert property (@(posedge CLOCK_I) disable iff (RST_I) // RL12
        timed_start_s |=> INTEGRATOR_RESET_O)
        else $error("timed reset ended early");
    // A spent timer releases the integrator although the condition holds
    timer_end_a: assert property (@(posedge CLOCK_I) disable iff (RST_I) // RL11
        timer_spent_s |=> !INTEGRATOR_RESET_O)
        else $error("timed reset overran its duration");

    // Internal fault reaches the pin one cycle later
    fault_pin_a: assert property (@(posedge CLOCK_I) disable iff (RST_I) // RL18
        fault |=> FAULT_O)
        else $error("fault not on pin");
    // Fault holds both ports at minimum
    fault_hold_a: assert property (@(posedge CLOCK_I) disable iff (RST_I) // RL15
        fault |=> !SENSE_PORT_A_O && !SENSE_PORT_B_O)
        else $error("outputs not held at minimum in fault");
    // A fresh reset start clears the fault
    fault_clear_a: assert property (@(posedge CLOCK_I) disable iff (RST_I) // RL17
        fault && reset_begin |=> !fault)
        else $error("fault not cleared by reset start");
    // Expiry without a fresh reset raises the fault
    fault_set_a: assert property (@(posedge CLOCK_I) disable iff (RST_I) // RL15
        running && !reset_begin && wd_expire |=> fault)
        else $error("watchdog expiry did not raise fault");
    // Watchdog counter stops at the fixed limit
    wd_bound_a: assert property (@(posedge CLOCK_I) disable iff (RST_I) // RL16
        wd_cnt <= CNT_W'(WATCHDOG_LIMIT_CYC - 1))
        else $error("watchdog count beyond limit");

    // Nothing moves while calibration runs
    cal_quiet_a: assert property (@(posedge CLOCK_I) disable iff (RST_I) // RL20
        !running |=> !SENSE_PORT_A_O && !SENSE_PORT_B_O && !INTEGRATOR_RESET_O)
        else $error("activity during calibration");
    // Inputs only count after the full calibration length
    cal_length_a: assert property (@(posedge CLOCK_I) disable iff (RST_I) // RL20
        running |-> cal_cnt == CNT_W'(CAL_CYC))
        else $error("calibration ended early");

    // Single mode never uses port b
    single_port_a: assert property (@(posedge CLOCK_I) disable iff (RST_I) // RL1
        (mode == MODE_SINGLE) |=> !SENSE_PORT_B_O)
        else $error("single mode used port b");
    // Single mode measures at once when no reset or fault holds it off
    measure_start_a: assert property (@(posedge CLOCK_I) disable iff (RST_I) // RL21
        running && !fault && !rst_now && (mode == MODE_SINGLE) |=> SENSE_PORT_A_O)
        else $error("measurement did not start after reset");

    // Two-wire: a alone selects port a
    pp2_port_a_a: assert property (@(posedge CLOCK_I) disable iff (RST_I) // RL3
        (mode == MODE_PP2) && rin.a && !rin.b |=> sel == 2'h1)
        else $error("two-wire steering to port a wrong");
    // Two-wire: b alone selects port b
    pp2_port_b_a: assert property (@(posedge CLOCK_I) disable iff (RST_I) // RL3
        (mode == MODE_PP2) && rin.b && !rin.a |=> sel == 2'h2)
        else $error("two-wire steering to port b wrong");
    // Four-wire: a high and b low selects port b
    pp4_steer_a: assert property (@(posedge CLOCK_I) disable iff (RST_I) // RL4
        (mode == MODE_PP4) && rin.a && !rin.b ##1 (mode == MODE_PP4) |-> sel[1])
        else $error("four-wire steering wrong");
    // Four-wire: c high and d low selects port a
    pp4_port_a_a: assert property (@(posedge CLOCK_I) disable iff (RST_I) // RL4
        (mode == MODE_PP4) && rin.c && !rin.d |=> sel[0])
        else $error("four-wire steering to port a wrong");

    // Single-only variant decodes a xor b
    xor_mode_a: assert property (@(posedge CLOCK_I) disable iff (RST_I) // RL9
        running && !dual |-> cond == (rin.a ^ rin.b))
        else $error("single variant condition wrong");
    // Bypass reset ends right after the condition drops
    drop_seq_a: assert property (@(posedge CLOCK_I) disable iff (RST_I) // RL10
        cond_drop_s |=> !INTEGRATOR_RESET_O)
        else $error("bypass reset lingered");
endmodule

/* gate_timing_model.sv */
`timescale 1ns/1ps
// Far side: converter switch timing levels on the four reset inputs
module gate_timing_model
    import isense_pkg::*;
(
    input wire logic two_wire_i,
    input wire reset_inputs_t want_i,
    output reset_inputs_t pins_o
);
    // Pattern set by the bench between transfers; c grounded in two-wire use
    assign pins_o = {want_i.d, want_i.c & ~two_wire_i, want_i.b, want_i.a};
endmodule

/* integrator_reset_steer_tb.sv */
`timescale 1ns/1ps
module integrator_reset_steer_tb;
    import isense_pkg::*;
    logic clk = 1'b0; // 125 MHz
    logic rst = 1'b1; // Sync reset
    logic mode_pin = 1'b1; // Single or two-wire
    logic dual = 1'b1; // Dual-output variant
    logic bypass = 1'b1; // Timer bypassed
    // Timed reset length, 160 ns so it stays above the 150 ns floor
    logic [CNT_W-1:0] dur = 16'h0014;
    reset_inputs_t want = '0; // Requested pattern
    reset_inputs_t pins; // Pattern on the pins
    logic int_rst, port_a, port_b, fault, cal_busy;
    int failures = 0;
    int n_tests = 0;
    int cnt;

    // Free-running clock
    initial forever #4 clk = ~clk;

    gate_timing_model u_far (.two_wire_i(mode_pin & want.d), .want_i(want), .pins_o(pins));

    integrator_reset_steer u_dut (.CLOCK_I(clk), .RST_I(rst), .RESET_IN_A_I(pins.a),
        .RESET_IN_B_I(pins.b), .RESET_IN_C_I(pins.c), .RESET_IN_D_I(pins.d),
        .MODE_PIN_I(mode_pin), .DUAL_VARIANT_I(dual), .TIMER_BYPASS_I(bypass),
        .RESET_DURATION_I(dur), .INTEGRATOR_RESET_O(int_rst), .SENSE_PORT_A_O(port_a),
        .SENSE_PORT_B_O(port_b), .FAULT_O(fault), .CAL_BUSY_O(cal_busy));

    // One comparison, counted
    task check(input logic [4:0] got, input logic [4:0] exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("BAD at %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // Verdict and end of run
    task stop_test;
        $display("checks %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    // Up to four edges of latency plus margin
    task settle;
        repeat (5) @(negedge clk);
    endtask

    // Walk a range of patterns in bypass, expected level from the logic equations
    task run_table(input logic mp, input logic dv, input int lo, input int hi);
        logic [3:0] p;
        logic r;
        mode_pin = mp;
        dual = dv;
        for (int i = lo; i <= hi; i++) begin
            p = i[3:0];
            want = p;
            settle();
            // Fold the mode decode in the bench, independent of the design
            if (!dv) r = p[0] ^ p[1];
            else if (!mp) r = (p[0] & p[1]) | (p[2] & p[3]);
            else if (p[3]) r = ~(p[0] ^ p[1]);
            else r = p[0] ^ (p[1] | p[2]);
            check({int_rst, fault, 3'h0}, {r, 4'h0});
            if (mp && !p[3]) check({3'h0, port_b, port_a}, {3'h0, 1'b0, ~r});
        end
        $display("table mode %0d variant %0d done", mp, dv);
    endtask

    // Ping-pong steering in both modes
    task pingpong;
        want = 4'h9; settle(); check({3'h0, port_b, port_a}, 5'h01);
        want = 4'ha; settle(); check({3'h0, port_b, port_a}, 5'h02);
        want = 4'h8; settle(); check({int_rst, 2'h0, port_b, port_a}, 5'h10);
        mode_pin = 1'b0;
        want = 4'h1; settle(); check({3'h0, port_b, port_a}, 5'h02);
        want = 4'h4; settle(); check({3'h0, port_b, port_a}, 5'h01);
        $display("ping-pong done");
    endtask

    // Count reset-high cycles over n falling edges
    task count_rst(input int n);
        repeat (n) begin
            @(negedge clk);
            if (int_rst === 1'b1) cnt++;
        end
    endtask

    // Retriggerable timed pulse, full and cut short
    task timer;
        mode_pin = 1'b1;
        bypass = 1'b0;
        want = 4'h0; settle();
        cnt = 0; want = 4'h1; count_rst(30);
        check(cnt[4:0], 5'd20);
        want = 4'h0; settle();
        dur = 16'h0018;
        cnt = 0; want = 4'h1; count_rst(6);
        want = 4'h0; count_rst(20);
        check(cnt[4:0], 5'd6);
        bypass = 1'b1;
        $display("timer done");
    endtask

    // Starved resets trip the watchdog, next reset clears it
    task watchdog;
        want = 4'h0;
        // No fault before the 30 us floor of the detect window
        repeat (30 * CLK_MHZ - 50) @(negedge clk);
        check({fault, port_b, port_a, 2'h0}, 5'h04);
        // Fault must stand before the 80 us ceiling
        repeat (50 * CLK_MHZ) @(negedge clk);
        check({fault, port_b, port_a, 2'h0}, 5'h10);
        want = 4'h1; settle(); want = 4'h0; settle();
        check({fault, port_b, port_a, 2'h0}, 5'h04);
        $display("watchdog done");
    endtask

    // Main sequence
    initial begin
        repeat (5) @(negedge clk);
        check({int_rst, port_a, port_b, fault, cal_busy}, 5'h01);
        rst = 1'b0;
        cnt = 0;
        while (cal_busy !== 1'b0 && cnt < 200) begin
            @(negedge clk);
            cnt++;
        end
        check({4'h0, cal_busy}, 5'h00);
        run_table(1'b1, 1'b1, 0, 7);
        run_table(1'b1, 1'b1, 8, 11);
        run_table(1'b0, 1'b1, 0, 15);
        run_table(1'b1, 1'b0, 0, 3);
        dual = 1'b1;
        pingpong();
        timer();
        watchdog();
        stop_test();
    end

    // Hang guard, well past the expected run
    initial begin
        #(8 * 20000);
        failures++;
        stop_test();
    end
endmodule
